//--- tec_pkg.sv
// Shared constants and types for the timer/event counter block.
// Assumes a single 50 MHz peripheral clock and byte-addressed register access.
package tec_pkg;

  // Register byte addresses.
  localparam logic [15:0] ADDR_PORT0_DIR   = 16'hff20;
  localparam logic [15:0] ADDR_PRESCALER   = 16'hffbb;
  localparam logic [15:0] ADDR_OUT_CTRL    = 16'hffbd;
  localparam logic [15:0] ADDR_MODE_CTRL   = 16'hffba;
  localparam logic [15:0] ADDR_COUNTER     = 16'hffb0;
  localparam logic [15:0] ADDR_FIRST_CMP   = 16'hffb2;
  localparam logic [15:0] ADDR_SECOND_CMP  = 16'hffb4;

  // Reset values.
  localparam logic [7:0]  PORT0_DIR_RST    = 8'hff;
  localparam logic [7:0]  CTRL_RST         = 8'h00;
  localparam logic [15:0] CMP_RST          = 16'h0000;

  // Field positions.
  localparam int OPM_HI     = 3;  // Operating-mode field, high bit.
  localparam int OPM_LO     = 2;  // Operating-mode field, low bit.
  localparam int CKS_HI     = 1;  // Clock select, high bit.
  localparam int CKS_LO     = 0;  // Clock select, low bit.
  localparam int EDGE_HI    = 5;  // Event pin edge select, high bit.
  localparam int EDGE_LO    = 4;  // Event pin edge select, low bit.
  localparam int TOE_BIT    = 0;  // Output enable.
  localparam int TG1_BIT    = 1;  // Toggle on first compare match.
  localparam int LVR_BIT    = 2;  // Trigger: force output low.
  localparam int LVS_BIT    = 3;  // Trigger: force output high.
  localparam int TG2_BIT    = 4;  // Toggle on second compare match.

  // Field encodings.
  localparam logic [1:0] OPM_STOP     = 2'b00;
  localparam logic [1:0] OPM_MATCH    = 2'b11;
  localparam logic [1:0] CKS_FULL     = 2'b00;
  localparam logic [1:0] CKS_DIV4     = 2'b01;
  localparam logic [1:0] CKS_DIV256   = 2'b10;
  localparam logic [1:0] CKS_EVENT    = 2'b11;
  localparam logic [1:0] EDGE_FALL    = 2'b00;
  localparam logic [1:0] EDGE_RISE    = 2'b01;
  localparam logic [1:0] EDGE_BOTH    = 2'b11;

  // Prescaler terminal counts for the two divided rates.
  localparam logic [7:0] DIV4_LAST    = 8'h03;
  localparam logic [7:0] DIV256_LAST  = 8'hff;

  // Counter sequencing states.
  typedef enum logic [1:0] {
    ST_STOP = 2'b00,  // Stopped, counter held at zero.
    ST_ARM  = 2'b01,  // Waiting for the first event edge.
    ST_RUN  = 2'b10   // Counting.
  } tec_state_t;

endpackage

//--- tec_edge_filter.sv
// Event pin sampler with two-sample noise rejection and edge selection.
// Assumes the pin is synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module tec_edge_filter (
  // Clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Pin and edge choice.
  input  wire logic       i_pin,
  input  wire logic [1:0] i_edge_sel,
  // Accepted edge, one-cycle pulse.
  output logic            o_edge
);

  logic samp_a_r;  // Latest sample of the pin.
  logic samp_b_r;  // Previous sample of the pin.
  logic level_r;   // Accepted, filtered level.

  // Sample the pin every clock.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      samp_a_r <= 1'b0;
      samp_b_r <= 1'b0;
    end else begin
      samp_a_r <= i_pin;
      samp_b_r <= samp_a_r;
    end
  end

  // Accept a new level only when two samples agree.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      level_r <= 1'b0;
      o_edge  <= 1'b0;
    end else if (samp_a_r == samp_b_r && samp_a_r != level_r) begin
      level_r <= samp_a_r;
      case (i_edge_sel)
        tec_pkg::EDGE_RISE: o_edge <= samp_a_r;
        tec_pkg::EDGE_BOTH: o_edge <= 1'b1;
        default:            o_edge <= ~samp_a_r;
      endcase
    end else begin
      o_edge <= 1'b0;
    end
  end

  // An accepted edge always follows two equal samples of the pin itself.
  AST_FILTER_TWO_SAMPLES: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_edge |-> $past(i_pin, 2) == $past(i_pin, 3))
    else $error("Edge accepted without two equal samples.");

endmodule
`default_nettype wire

//--- tec_timer.sv
// Timer/event counter top: registers, prescaler, counter and output toggle.
// Assumes a simple synchronous register port and synchronous pins.
`timescale 1ns/1ps
`default_nettype none
module tec_timer #(
  parameter int CNT_W = 16  // Counter and compare width.
) (
  // Clock and reset.
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // Register access port.
  input  wire logic [15:0]      i_addr,
  input  wire logic [CNT_W-1:0] i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [CNT_W-1:0] o_rdata,
  // Pins.
  input  wire logic             i_event_pin,
  output logic                  o_timer_out,
  output logic      [1:0]       o_port_oe_n,
  // Match interrupt requests, one-cycle pulses.
  output logic                  o_first_match_irq,
  output logic                  o_second_match_irq
);

  // Refuse widths the register layout cannot hold.
  if (CNT_W < 8 || CNT_W > 16) begin : g_chk
    $error("CNT_W must lie between 8 and 16.");
  end

  // Equality of the counter with a compare register.
  function automatic logic tec_hit(input logic [CNT_W-1:0] a,
                                   input logic [CNT_W-1:0] b);
    tec_hit = (a == b);
  endfunction

  logic [7:0]       port0_direction_r;  // Pin direction bits.
  logic [7:0]       mode_ctrl_r;        // Operating-mode register.
  logic [7:0]       out_ctrl_r;         // Output control register.
  logic [7:0]       prescaler_r;        // Clock and edge selection.
  logic [CNT_W-1:0] first_cmp_r;        // First compare value.
  logic [CNT_W-1:0] second_cmp_r;       // Second compare value.
  logic [CNT_W-1:0] counter_r;          // Up counter.
  logic [7:0]       div_r;              // Prescaler divider.
  tec_pkg::tec_state_t state_r;         // Counter sequencing state.
  tec_pkg::tec_state_t state_nxt;       // Next sequencing state.
  logic             run;                // Mode field asks to count.
  logic             event_edge;         // Filtered event pin edge.
  logic             tick;               // Count clock enable.
  logic             counting;           // Tick that advances the counter.
  logic             hit1;               // First compare match this tick.
  logic             hit2;               // Second compare match this tick.
  logic [1:0]       cks;                // Selected clock source.
  logic             wr_out_ctrl;        // Write to output control.

  assign run         = mode_ctrl_r[tec_pkg::OPM_HI:tec_pkg::OPM_LO]
                       == tec_pkg::OPM_MATCH;
  assign cks         = prescaler_r[tec_pkg::CKS_HI:tec_pkg::CKS_LO];
  assign wr_out_ctrl = i_wr && i_addr == tec_pkg::ADDR_OUT_CTRL;

  // Edge filter for the external event pin.
  tec_edge_filter u_edge (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_pin      (i_event_pin),
    .i_edge_sel (prescaler_r[tec_pkg::EDGE_HI:tec_pkg::EDGE_LO]),
    .o_edge     (event_edge)
  );

  // Select the count clock enable from the prescaler or the event edge.
  always_comb begin
    case (cks)
      tec_pkg::CKS_FULL:   tick = run;
      tec_pkg::CKS_DIV4:   tick = run && div_r[1:0] == tec_pkg::DIV4_LAST[1:0];
      tec_pkg::CKS_DIV256: tick = run && div_r == tec_pkg::DIV256_LAST;
      default:             tick = run && event_edge;
    endcase
  end

  // The first event edge after start only arms the counter.
  assign counting = tick && state_r == tec_pkg::ST_RUN;
  assign hit1     = counting && tec_hit(counter_r, first_cmp_r);
  assign hit2     = counting && tec_hit(counter_r, second_cmp_r);

  // Prescaler divider, held at zero while stopped.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r <= 8'h00;
    end else if (!run) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // Sequencing: stop, arm on event clock, run.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      tec_pkg::ST_STOP: begin
        if (run) begin
          state_nxt = (cks == tec_pkg::CKS_EVENT) ? tec_pkg::ST_ARM
                                                  : tec_pkg::ST_RUN;
        end
      end
      tec_pkg::ST_ARM: begin
        if (!run) begin
          state_nxt = tec_pkg::ST_STOP;
        end else if (tick) begin
          state_nxt = tec_pkg::ST_RUN;
        end
      end
      tec_pkg::ST_RUN: begin
        if (!run) begin
          state_nxt = tec_pkg::ST_STOP;
        end
      end
      default: state_nxt = tec_pkg::ST_STOP;
    endcase
  end

  // State register.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= tec_pkg::ST_STOP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Up counter: clear on first compare match, otherwise count.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      counter_r <= '0;
    end else if (!run) begin
      counter_r <= '0;
    end else if (hit1) begin
      counter_r <= '0;
    end else if (counting) begin
      counter_r <= counter_r + 1'b1;
    end
  end

  // Match interrupt pulses.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_first_match_irq  <= 1'b0;
      o_second_match_irq <= 1'b0;
    end else begin
      o_first_match_irq  <= hit1;
      o_second_match_irq <= hit2;
    end
  end

  // Timer output: low unless enabled, forced by triggers, toggled on match.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_timer_out <= 1'b0;
    end else if (!out_ctrl_r[tec_pkg::TOE_BIT]) begin
      o_timer_out <= 1'b0;
    end else if (wr_out_ctrl && i_wdata[tec_pkg::LVS_BIT]) begin
      o_timer_out <= 1'b1;
    end else if (wr_out_ctrl && i_wdata[tec_pkg::LVR_BIT]) begin
      o_timer_out <= 1'b0;
    end else if ((hit1 && out_ctrl_r[tec_pkg::TG1_BIT]) ||
                 (hit2 && out_ctrl_r[tec_pkg::TG2_BIT])) begin
      o_timer_out <= ~o_timer_out;
    end
  end

  // Register writes; trigger bits of output control are not stored.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      port0_direction_r <= tec_pkg::PORT0_DIR_RST;
      mode_ctrl_r       <= tec_pkg::CTRL_RST;
      out_ctrl_r        <= tec_pkg::CTRL_RST;
      prescaler_r       <= tec_pkg::CTRL_RST;
      first_cmp_r       <= CNT_W'(tec_pkg::CMP_RST);
      second_cmp_r      <= CNT_W'(tec_pkg::CMP_RST);
    end else if (i_wr) begin
      if (i_addr == tec_pkg::ADDR_PORT0_DIR) begin
        port0_direction_r <= {6'h3f, i_wdata[1:0]};
      end else if (i_addr == tec_pkg::ADDR_MODE_CTRL) begin
        mode_ctrl_r <= {4'h0, i_wdata[3:2], 2'b00};
      end else if (i_addr == tec_pkg::ADDR_OUT_CTRL) begin
        out_ctrl_r <= {3'b000, i_wdata[4], 2'b00, i_wdata[1:0]};
      end else if (i_addr == tec_pkg::ADDR_PRESCALER) begin
        prescaler_r <= {2'b00, i_wdata[5:4], 2'b00, i_wdata[1:0]};
      end else if (i_addr == tec_pkg::ADDR_FIRST_CMP) begin
        first_cmp_r <= i_wdata;
      end else if (i_addr == tec_pkg::ADDR_SECOND_CMP) begin
        second_cmp_r <= i_wdata;
      end
    end
  end

  // Pin output enables follow the direction bits, low while driving.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_port_oe_n <= 2'b11;
    end else begin
      o_port_oe_n <= port0_direction_r[1:0];
    end
  end

  // Read data, registered; unmapped addresses read zero.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      if (i_addr == tec_pkg::ADDR_PORT0_DIR) begin
        o_rdata <= CNT_W'(port0_direction_r);
      end else if (i_addr == tec_pkg::ADDR_MODE_CTRL) begin
        o_rdata <= CNT_W'(mode_ctrl_r);
      end else if (i_addr == tec_pkg::ADDR_OUT_CTRL) begin
        o_rdata <= CNT_W'(out_ctrl_r);
      end else if (i_addr == tec_pkg::ADDR_PRESCALER) begin
        o_rdata <= CNT_W'(prescaler_r);
      end else if (i_addr == tec_pkg::ADDR_COUNTER) begin
        o_rdata <= counter_r;
      end else if (i_addr == tec_pkg::ADDR_FIRST_CMP) begin
        o_rdata <= first_cmp_r;
      end else if (i_addr == tec_pkg::ADDR_SECOND_CMP) begin
        o_rdata <= second_cmp_r;
      end else begin
        o_rdata <= '0;
      end
    end
  end

  // A divide-by-four tick is followed by three idle cycles.
  sequence s_div4_idle;
    !tick [*3];
  endsequence

  // A first compare match clears the counter and raises the interrupt.
  sequence s_clear_and_irq;
    counter_r == '0 && o_first_match_irq;
  endsequence

  AST_DIR_UPPER_ONES: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_rd && i_addr == tec_pkg::ADDR_PORT0_DIR |=> o_rdata[7:2] == 6'h3f)
    else $error("Direction register upper bits did not read as one.");

  AST_STOP_QUIET: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !run |=> !o_first_match_irq && !o_second_match_irq && counter_r == '0)
    else $error("Stopped counter produced activity.");

  AST_MATCH_CLEAR: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    run && counting && counter_r == first_cmp_r |=> s_clear_and_irq)
    else $error("First match did not clear counter and interrupt.");

  AST_SQUARE_TOGGLE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    hit1 && out_ctrl_r[1:0] == 2'b11 && !wr_out_ctrl
    |=> o_timer_out != $past(o_timer_out))
    else $error("Output did not toggle on first match.");

  AST_OUT_LOW: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !out_ctrl_r[tec_pkg::TOE_BIT] |=> !o_timer_out)
    else $error("Output not low while disabled.");

  AST_SECOND_IRQ: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    counting && counter_r == second_cmp_r |=> o_second_match_irq)
    else $error("Second match interrupt missing.");

  AST_COUNT_UP: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    run && counting && counter_r != first_cmp_r
    |=> counter_r == $past(counter_r) + 1'b1)
    else $error("Counter failed to advance on tick.");

  AST_DIV4_RATE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    tick && cks == tec_pkg::CKS_DIV4 && $stable(prescaler_r) && run
    ##1 run |-> s_div4_idle)
    else $error("Divide-by-four tick spacing wrong.");

  AST_READ_COUNT: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_rd && i_addr == tec_pkg::ADDR_COUNTER
    |=> o_rdata == $past(counter_r))
    else $error("Counter read returned wrong value.");

  // The arming edge moves to counting without advancing or matching.
  AST_EVENT_ARM: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    state_r == tec_pkg::ST_ARM && tick
    |=> state_r == tec_pkg::ST_RUN && counter_r == '0 && !o_first_match_irq)
    else $error("Arming edge advanced the counter or raised a match.");

endmodule
`default_nettype wire

//--- tec_event_src.sv
// Far-side model: event pulse source on the event pin and timer output load.
// Assumes the bench calls its pulse task and reads its toggle count.
`timescale 1ns/1ps
`default_nettype none
module tec_event_src (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Timer output seen by the load.
  input  wire logic i_timer_out,
  // Event pin driven by the source.
  output logic      o_pin
);
  int   toggles;   // Level changes seen on the timer output.
  logic last_out;  // Output level at the previous edge.

  // The pin idles low so no false edge is seen after reset.
  initial o_pin = 1'b0;

  // The load counts every change of the timer output level.
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      toggles  <= 0;
      last_out <= 1'b0;
    end else begin
      last_out <= i_timer_out;
      if (i_timer_out !== last_out) begin
        toggles <= toggles + 1;
      end
    end
  end

  // A high pulse of the given width, then a quiet low gap.
  // Real pulses stay high for 3 cycles; width 1 is a noise glitch.
  task automatic pulse(input int hi);
    @(negedge i_clk);
    o_pin = 1'b1;
    repeat (hi) @(negedge i_clk);
    o_pin = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench of the timer/event counter top.
// Assumes the event source model drives the event pin.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module testbench;
  logic        i_clk;              // 50 MHz clock.
  logic        i_rst_n;            // Active-low reset.
  logic [15:0] i_addr;             // Register address.
  logic [15:0] i_wdata;            // Write data.
  logic        i_wr;               // Write strobe.
  logic        i_rd;               // Read strobe.
  logic [15:0] o_rdata;            // Read data.
  wire logic   i_event_pin;        // Event pin from the source.
  logic        o_timer_out;        // Timer output.
  logic [1:0]  o_port_oe_n;        // Pin output enables.
  logic        o_first_match_irq;  // First match pulse.
  logic        o_second_match_irq; // Second match pulse.
  int          mismatches;         // Failed comparisons.
  int          check_count;        // All comparisons.
  int          cyc;                // Cycle counter.
  int          nf;                 // First match pulses seen.
  int          ns;                 // Second match pulses seen.
  int          nco;                // Toggles coinciding with first match.
  int          tq[$];              // Times of first match pulses.
  int          sq[$];              // Times of second match pulses.
  logic        prev_out;           // Output level one edge earlier.

  tec_timer dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_event_pin(i_event_pin), .o_timer_out(o_timer_out),
    .o_port_oe_n(o_port_oe_n), .o_first_match_irq(o_first_match_irq),
    .o_second_match_irq(o_second_match_irq));
  tec_event_src src (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_timer_out(o_timer_out), .o_pin(i_event_pin));

  // Clock generator, 20 ns period.
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Monitor: counts pulses and records when first matches occur.
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (o_first_match_irq === 1'b1) begin
      nf = nf + 1;
      tq.push_back(cyc);
      if (o_timer_out !== prev_out) nco = nco + 1;
    end
    if (o_second_match_irq === 1'b1) begin
      ns = ns + 1;
      sq.push_back(cyc);
    end
    prev_out = o_timer_out;
  end

  // One comparison, reported at once when it differs.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %0h expected %0h", $time, g, e);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic end_of_test();
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Register write: one strobe cycle, changed at falling edges.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge i_clk);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_clk);
    i_wr = 1'b0;
  endtask

  // Register read: data is registered at the taking edge.
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge i_clk);
    i_addr = a;
    i_rd = 1'b1;
    @(negedge i_clk);
    i_rd = 1'b0;
    d = o_rdata;
  endtask

  // Stops the counter and clears the bench tallies.
  task automatic stop_all();
    wr(tec_pkg::ADDR_MODE_CTRL, 16'h0000);
    wr(tec_pkg::ADDR_OUT_CTRL, 16'h0000);
    nf = 0;
    ns = 0;
    nco = 0;
    tq.delete();
    sq.delete();
  endtask

  // Interval run: four first matches, counter read while running.
  task automatic run_interval(input logic [1:0] cks, input logic [7:0] toc,
                              input int m, input int cr1);
    logic [15:0] d;
    int          k;
    int          base;
    int          dv;
    int          tg;
    dv = (cks == tec_pkg::CKS_FULL) ? 1 : (cks == tec_pkg::CKS_DIV4) ? 4 : 256;
    stop_all();
    wr(tec_pkg::ADDR_PRESCALER, {14'h0000, cks});
    wr(tec_pkg::ADDR_FIRST_CMP, 16'(m));
    wr(tec_pkg::ADDR_SECOND_CMP, 16'(cr1));
    wr(tec_pkg::ADDR_OUT_CTRL, {8'h00, toc});
    nf = 0;
    ns = 0;
    nco = 0;
    tq.delete();
    sq.delete();
    base = src.toggles;
    wr(tec_pkg::ADDR_MODE_CTRL, 16'h000c);
    k = 0;
    while (nf < 4 && k < 3000) begin
      rd(tec_pkg::ADDR_COUNTER, d);
      `CHK(d <= 16'(m), 1);
      k++;
    end
    `CHK(k < 3000, 1);
    `CHK(tq[3] - tq[0], 3 * (m + 1) * dv);
    wr(tec_pkg::ADDR_MODE_CTRL, 16'h0000);
    repeat (2) @(negedge i_clk);
    // Each period's second match leads its first match by (m - cr1) ticks.
    for (int i = 0; i < 4; i++) begin
      `CHK(tq[i] - sq[i], (m - cr1) * dv);
    end
    tg = src.toggles - base;
    if (toc == 8'h03) begin
      `CHK(tg, nf);
      `CHK(nco, nf);
    end else if (toc == 8'h11) begin
      `CHK(tg, ns);
    end else if (toc == 8'h13) begin
      `CHK(tg, nf + ns);
    end else begin
      `CHK(tg, 0);
      `CHK(o_timer_out, 1'b0);
    end
    k = nf;
    repeat (30) @(negedge i_clk);
    `CHK(nf, k);
    rd(tec_pkg::ADDR_COUNTER, d);
    `CHK(d, 16'h0000);
  endtask

  // Main sequence.
  initial begin
    logic [15:0] d;
    logic [7:0]  v;
    logic [7:0]  tocs [4];
    int          m;
    int          ex;
    i_rst_n = 1'b0;
    i_addr = 16'h0000;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    mismatches = 0;
    check_count = 0;
    cyc = 0;
    nf = 0;
    ns = 0;
    nco = 0;
    prev_out = 1'b0;
    tocs = '{8'h03, 8'h11, 8'h13, 8'h02};
    void'($urandom(63));
    repeat (6) @(posedge i_clk);
    `CHK(o_port_oe_n, 2'b11);
    @(negedge i_clk);
    i_rst_n = 1'b1;
    // Reset values and refused accesses.
    rd(tec_pkg::ADDR_PORT0_DIR, d);
    `CHK(d[7:0], 8'hff);
    wr(tec_pkg::ADDR_COUNTER, 16'h1234);
    rd(tec_pkg::ADDR_COUNTER, d);
    `CHK(d, 16'h0000);
    rd(16'hff00, d);
    `CHK(d, 16'h0000);
    // Direction bits: both pins output, then two random patterns.
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h00 : 8'($urandom);
      wr(tec_pkg::ADDR_PORT0_DIR, {8'h00, v});
      rd(tec_pkg::ADDR_PORT0_DIR, d);
      `CHK(d[7:0], {6'h3f, v[1:0]});
      `CHK(o_port_oe_n, v[1:0]);
    end
    wr(tec_pkg::ADDR_PORT0_DIR, 16'h0001);
    // Output control choices at the full rate.
    for (int i = 0; i < 4; i++) begin
      m = 2 + $urandom % 6;
      run_interval(tec_pkg::CKS_FULL, tocs[i], m, 1 + $urandom % (m - 1));
    end
    // Each divided internal count clock.
    run_interval(tec_pkg::CKS_DIV4, 8'h03, 3, 1);
    run_interval(tec_pkg::CKS_DIV256, 8'h03, 2, 1);
    // Level triggers act while the output stays enabled and read as zero.
    wr(tec_pkg::ADDR_OUT_CTRL, 16'h000b);
    `CHK(o_timer_out, 1'b1);
    wr(tec_pkg::ADDR_OUT_CTRL, 16'h0007);
    `CHK(o_timer_out, 1'b0);
    rd(tec_pkg::ADDR_OUT_CTRL, d);
    `CHK(d, 16'h0003);
    // Event counting on rising edges, with glitches in between.
    wr(tec_pkg::ADDR_PORT0_DIR, 16'h0003);
    stop_all();
    m = 1 + $urandom % 4;
    wr(tec_pkg::ADDR_PRESCALER, 16'h0013);
    wr(tec_pkg::ADDR_FIRST_CMP, 16'(m));
    wr(tec_pkg::ADDR_SECOND_CMP, 16'hffff);
    wr(tec_pkg::ADDR_MODE_CTRL, 16'h000c);
    nf = 0;
    for (int k = 1; k <= 3 * m + 4; k++) begin
      src.pulse(1);
      src.pulse(3);
      ex = (k < m + 2) ? 0 : 1 + (k - m - 2) / (m + 1);
      `CHK(nf, ex);
    end
    end_of_test();
  end

  // Watchdog: far longer than the whole sequence needs.
  initial begin
    repeat (40000) @(posedge i_clk);
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire
